// ==== verilog/sfcfp_top.sv ====
// Purpose: command framing, write latch and protection front end of a serial flash
// Assumes: serial clock is the link domain and stops outside frames; array backend
//          and busy_in live on clk_sys_in
// Notes:
// Notes on behaviour
// - reset puts command logic into standby
// - change contents only after accepted command
// - partial-byte frames are invalid
// - modifying commands need write latch set
// - deep sleep ignores all; chip select wakes
// - protect level makes region read-only
// - levels one to four protect top 1,2,4,8
// - levels five and up protect everything
// - protect pin locks level and lock bit, except in quad mode
// - chip erase only when level is zero
// - map address to sectors and blocks
// - unknown opcode: standby, output released
// - known opcode: active until select rises
// - sample on rising, drive on falling edge
// - works with clock idling low or high
// - reads may stop after any bit
// - write-type commands end on byte boundary
// - busy: ignore access, operation continues
// - two-line read drives both data lines
// - write latch cleared by listed completions
`timescale 1ns/1ps
module sfcfp_top
    import sfcfp_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic sclk_in,
    input wire logic cs_n_in,
    input wire logic data_line0_in,
    output logic data_line0_out,
    output logic data_line0_oe_out,
    input wire logic data_line1_in,
    output logic data_line1_out,
    output logic data_line1_oe_out,
    input wire logic write_protect_n_in,
    input wire logic quad_mode_in,
    input wire logic [7:0] array_byte_in,
    output logic [23:0] read_addr_out,
    output logic link_active_out,
    output logic [7:0] status_out,
    output logic deep_sleep_out,
    output logic op_start_out,
    output logic [2:0] op_kind_out,
    output logic [19:0] op_addr_out,
    output logic [8:0] op_len_out,
    input wire logic op_busy_in,
    input wire logic op_done_in,
    input wire logic [7:0] pbuf_raddr_in,
    output logic [7:0] pbuf_rdata_out,
    output logic cmd_refused_out
);
    // ---------------- link domain (serial clock) ----------------
    logic [2:0] bit_cnt_q;
    logic [2:0] byte_cnt_q;
    logic [6:0] sr_q;
    logic [7:0] rx_byte_q;
    logic rx_tgl_q;
    logic [7:0] l_op_q;
    logic [23:0] l_addr_q;
    logic [2:0] cnt_bin_q;
    logic [2:0] cnt_gray_q;
    logic data_phase_q;
    sfcfp_link_mode_t mode_q;
    logic [7:0] st_l1_q, st_l2_q;
    logic sleep_l1_q, sleep_l2_q;
    logic [7:0] status_q;
    logic sleep_q;
    logic [7:0] rx_next;
    logic [2:0] start_bytes;

    assign rx_next = {sr_q, data_line0_in};
    assign start_bytes = sfcfp_data_start(l_op_q);

    // frame state is cleared by the select pin itself, so nothing depends on a
    // serial clock edge after the frame ends
    always_ff @(posedge sclk_in or negedge rst_n_in or posedge cs_n_in) begin
        if (!rst_n_in || cs_n_in) begin
            bit_cnt_q <= 3'h0;
            byte_cnt_q <= 3'h0;
            sr_q <= 7'h00;
        end else begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            sr_q <= rx_next[6:0];
            if (bit_cnt_q == 3'h7 && byte_cnt_q != 3'h7) begin
                byte_cnt_q <= byte_cnt_q + 3'h1;
            end
        end
    end

    // opcode and address captured in the link domain for the output path
    always_ff @(posedge sclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            l_op_q <= 8'h00;
            l_addr_q <= 24'h000000;
        end else if (!cs_n_in && bit_cnt_q == 3'h7) begin
            if (byte_cnt_q == 3'h0) begin
                l_op_q <= rx_next;
            end else if (byte_cnt_q < 3'h4) begin
                l_addr_q <= {l_addr_q[15:0], rx_next};
            end
        end
    end

    // whole bytes cross by toggle; the byte stays put for eight serial clocks
    always_ff @(posedge sclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_byte_q <= 8'h00;
            rx_tgl_q <= 1'b0;
        end else if (!cs_n_in && bit_cnt_q == 3'h7) begin
            rx_byte_q <= rx_next;
            rx_tgl_q <= ~rx_tgl_q;
        end
    end

    // free bit count, gray coded so the system side can check byte alignment
    always_ff @(posedge sclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_bin_q <= 3'h0;
            cnt_gray_q <= 3'h0;
        end else if (!cs_n_in) begin
            cnt_bin_q <= cnt_bin_q + 3'h1;
            cnt_gray_q <= (cnt_bin_q + 3'h1) ^ ((cnt_bin_q + 3'h1) >> 1);
        end
    end

    // status and sleep are synchronised per bit; they are fresh by opcode end
    always_ff @(posedge sclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_l1_q <= 8'h00;
            st_l2_q <= 8'h00;
            sleep_l1_q <= 1'b0;
            sleep_l2_q <= 1'b0;
        end else begin
            st_l1_q <= status_q;
            st_l2_q <= st_l1_q;
            sleep_l1_q <= sleep_q;
            sleep_l2_q <= sleep_l1_q;
        end
    end

    always_ff @(posedge sclk_in or negedge rst_n_in or posedge cs_n_in) begin
        if (!rst_n_in || cs_n_in) begin
            mode_q <= LM_IDLE;
            data_phase_q <= 1'b0;
        end else if (bit_cnt_q == 3'h7) begin
            if (byte_cnt_q == 3'h0) begin
                if (sleep_l2_q || !sfcfp_known(rx_next)) begin
                    mode_q <= LM_STANDBY;
                end else begin
                    mode_q <= LM_ACTIVE;
                    data_phase_q <= (sfcfp_data_start(rx_next) == 3'h1);
                end
            end else if (mode_q == LM_ACTIVE && start_bytes != 3'h0
                         && byte_cnt_q + 3'h1 == start_bytes) begin
                data_phase_q <= 1'b1;
            end
        end
    end

    // output path on falling edges
    logic tx_on_q;
    logic [7:0] tx_sr_q;
    logic [2:0] tx_cnt_q;
    logic dual;
    logic [7:0] tx_src;
    logic tx_allow;

    assign dual = (l_op_q == OP_TWO_RD);
    always_comb begin
        case (l_op_q)
            OP_STAT_RD: tx_src = st_l2_q;
            OP_IDENT_RD, OP_SIG_RD, OP_MAKER_RD: tx_src = ID_BYTE;
            default: tx_src = array_byte_in;
        endcase
    end
    // reads of the array are dropped while a program or erase runs
    assign tx_allow = (mode_q == LM_ACTIVE)
                      && (l_op_q == OP_STAT_RD || !st_l2_q[ST_BUSY]);

    always_ff @(negedge sclk_in or negedge rst_n_in or posedge cs_n_in) begin
        if (!rst_n_in || cs_n_in) begin
            tx_on_q <= 1'b0;
            tx_sr_q <= 8'h00;
            tx_cnt_q <= 3'h0;
        end else if (!tx_on_q) begin
            if (data_phase_q) begin
                tx_on_q <= 1'b1;
                tx_sr_q <= tx_src;
                tx_cnt_q <= 3'h0;
            end
        end else if (tx_cnt_q == (dual ? 3'h6 : 3'h7)) begin
            tx_sr_q <= tx_src;
            tx_cnt_q <= 3'h0;
        end else if (dual) begin
            tx_sr_q <= {tx_sr_q[5:0], 2'b00};
            tx_cnt_q <= tx_cnt_q + 3'h2;
        end else begin
            tx_sr_q <= {tx_sr_q[6:0], 1'b0};
            tx_cnt_q <= tx_cnt_q + 3'h1;
        end
    end

    // standby or sleep keeps both lines released
    assign data_line1_out = tx_sr_q[7];
    assign data_line1_oe_out = tx_on_q && tx_allow;
    assign data_line0_out = tx_sr_q[6];
    assign data_line0_oe_out = tx_on_q && tx_allow && dual;
    assign link_active_out = (mode_q == LM_ACTIVE);
    assign read_addr_out = l_addr_q;

    // ---------------- system domain ----------------
    logic [4:0] cs_s_q;
    logic [2:0] tgl_s_q;
    logic [2:0] gray_s1_q, gray_s2_q;
    logic wp_s1_q, wp_s2_q;
    logic [2:0] last_end_q;
    logic [2:0] gray_bin;
    logic frame_end;
    logic byte_evt;

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cs_s_q <= 5'h1f;
            tgl_s_q <= 3'h0;
            gray_s1_q <= 3'h0;
            gray_s2_q <= 3'h0;
            wp_s1_q <= 1'b1;
            wp_s2_q <= 1'b1;
        end else begin
            cs_s_q <= {cs_s_q[3:0], cs_n_in};
            tgl_s_q <= {tgl_s_q[1:0], rx_tgl_q};
            gray_s1_q <= cnt_gray_q;
            gray_s2_q <= gray_s1_q;
            wp_s1_q <= write_protect_n_in;
            wp_s2_q <= wp_s1_q;
        end
    end

    assign gray_bin = {gray_s2_q[2], gray_s2_q[2] ^ gray_s2_q[1],
                       gray_s2_q[2] ^ gray_s2_q[1] ^ gray_s2_q[0]};
    // two cycles of slack after select rises so the last byte has landed
    assign frame_end = cs_s_q[3] && !cs_s_q[4];
    assign byte_evt = tgl_s_q[2] ^ tgl_s_q[1];

    // collected frame
    logic [9:0] nbytes_q;
    logic [7:0] op_q;
    logic [19:0] addr_q;
    logic [7:0] wr_stat_q;
    logic [7:0] pbuf [0:255];

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            nbytes_q <= 10'h000;
            op_q <= 8'h00;
            addr_q <= 20'h00000;
            wr_stat_q <= 8'h00;
        end else if (frame_end) begin
            nbytes_q <= 10'h000;
        end else if (byte_evt) begin
            if (nbytes_q != LEN_MAX) begin
                nbytes_q <= nbytes_q + 10'h001;
            end
            if (nbytes_q == 10'h000) begin
                op_q <= rx_byte_q;
            end else if (nbytes_q < LEN_ADDR) begin
                addr_q <= {addr_q[11:0], rx_byte_q};
            end
            if (nbytes_q == LEN_CMD) begin
                wr_stat_q <= rx_byte_q;
            end
        end
    end

    // page data is held until the frame proves complete
    always_ff @(posedge clk_sys_in) begin
        if (byte_evt && op_q == OP_PAGE_WR && nbytes_q >= LEN_ADDR) begin
            pbuf[nbytes_q[7:0] - LEN_ADDR[7:0]] <= rx_byte_q;
        end
        pbuf_rdata_out <= pbuf[pbuf_raddr_in];
    end

    // decision at frame end
    logic [3:0] level_q;
    logic lock_q;
    logic latch_q;
    logic aligned;
    logic hw_locked;
    logic addr_prot;
    logic [4:0] prot_n;
    logic go;
    logic set_latch, clr_latch, accept_op, accept_stat;

    assign aligned = ((gray_bin - last_end_q) == 3'h0);
    assign hw_locked = lock_q && !wp_s2_q && !quad_mode_in;
    assign prot_n = sfcfp_prot_count(level_q);
    assign addr_prot = (prot_n != 5'h00)
                       && ({1'b0, addr_q[19:BLK_LO]} >= BLK_TOTAL - prot_n);
    // a frame that wakes the device is otherwise ignored
    assign go = frame_end && aligned && !sleep_q && !op_busy_in;

    always_comb begin
        set_latch = 1'b0;
        clr_latch = 1'b0;
        accept_op = 1'b0;
        accept_stat = 1'b0;
        if (go) begin
            case (op_q)
                OP_SET_LATCH: set_latch = (nbytes_q == LEN_CMD);
                OP_CLR_LATCH: clr_latch = (nbytes_q == LEN_CMD);
                OP_STAT_WR: accept_stat = (nbytes_q == LEN_STAT_WR) && latch_q
                                          && !hw_locked;
                OP_PAGE_WR: accept_op = (nbytes_q > LEN_ADDR) && latch_q && !addr_prot;
                OP_SECT_ER, OP_HALF_ER, OP_BLK_ER:
                    accept_op = (nbytes_q == LEN_ADDR) && latch_q && !addr_prot;
                OP_CHIP_ER_A, OP_CHIP_ER_B:
                    accept_op = (nbytes_q == LEN_CMD) && latch_q
                                && (level_q == 4'h0);
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            last_end_q <= 3'h0;
        end else if (frame_end) begin
            last_end_q <= gray_bin;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sleep_q <= 1'b0;
        end else if (frame_end) begin
            sleep_q <= !sleep_q && go && op_q == OP_SLEEP
                       && nbytes_q == LEN_CMD;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            latch_q <= 1'b0;
        end else if (set_latch) begin
            latch_q <= 1'b1;
        end else if (clr_latch || accept_stat || op_done_in) begin
            latch_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            level_q <= 4'h0;
            lock_q <= 1'b0;
        end else if (accept_stat) begin
            level_q <= wr_stat_q[ST_LEVEL_LO +: 4];
            lock_q <= wr_stat_q[ST_LOCK];
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            op_start_out <= 1'b0;
            op_kind_out <= OPK_PROGRAM;
            op_addr_out <= 20'h00000;
            op_len_out <= 9'h000;
        end else begin
            op_start_out <= accept_op;
            if (accept_op) begin
                op_len_out <= 9'h000;
                case (op_q)
                    OP_PAGE_WR: begin
                        op_kind_out <= OPK_PROGRAM;
                        op_addr_out <= addr_q;
                        op_len_out <= (nbytes_q - LEN_ADDR > {1'b0, PAGE_BYTES})
                                      ? PAGE_BYTES : 9'(nbytes_q - LEN_ADDR);
                    end
                    OP_SECT_ER: begin
                        op_kind_out <= OPK_SECTOR;
                        op_addr_out <= addr_q & SECT_MASK;
                    end
                    OP_HALF_ER: begin
                        op_kind_out <= OPK_HALF;
                        op_addr_out <= addr_q & HALF_MASK;
                    end
                    OP_BLK_ER: begin
                        op_kind_out <= OPK_BLOCK;
                        op_addr_out <= addr_q & BLK_MASK;
                    end
                    default: begin
                        op_kind_out <= OPK_CHIP;
                        op_addr_out <= 20'h00000;
                    end
                endcase
            end
        end
    end

    // refused: a complete frame that neither read nor was accepted
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cmd_refused_out <= 1'b0;
        end else begin
            cmd_refused_out <= frame_end && !sleep_q && nbytes_q != 10'h000
                               && sfcfp_data_start(op_q) == 3'h0 && op_q != OP_SLEEP
                               && !(set_latch || clr_latch || accept_stat || accept_op);
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            status_q <= 8'h00;
        end else begin
            status_q <= {lock_q, 1'b0, level_q, latch_q, op_busy_in};
        end
    end

    assign status_out = status_q;
    assign deep_sleep_out = sleep_q;
endmodule : sfcfp_top

// ==== verilog/sfcfp_pkg.sv ====
// Purpose: shared constants and types for the serial flash command front end
// Assumes: 8-bit opcodes, 20 significant address bits (top address 0fffffh)
// Notes: status byte layout and id byte are local choices
package sfcfp_pkg;
    // opcodes
    localparam logic [7:0] OP_SET_LATCH = 8'h06;
    localparam logic [7:0] OP_CLR_LATCH = 8'h04;
    localparam logic [7:0] OP_STAT_RD = 8'h05;
    localparam logic [7:0] OP_STAT_WR = 8'h01;
    localparam logic [7:0] OP_PAGE_WR = 8'h02;
    localparam logic [7:0] OP_SECT_ER = 8'h20;
    localparam logic [7:0] OP_HALF_ER = 8'h52;
    localparam logic [7:0] OP_BLK_ER = 8'hd8;
    localparam logic [7:0] OP_CHIP_ER_A = 8'h60;
    localparam logic [7:0] OP_CHIP_ER_B = 8'hc7;
    localparam logic [7:0] OP_SLEEP = 8'hb9;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_FAST_RD = 8'h0b;
    localparam logic [7:0] OP_TWO_RD = 8'h3b;
    localparam logic [7:0] OP_PARAM_RD = 8'h5a;
    localparam logic [7:0] OP_IDENT_RD = 8'h9f;
    localparam logic [7:0] OP_SIG_RD = 8'hab;
    localparam logic [7:0] OP_MAKER_RD = 8'h90;
    // status byte fields
    localparam int ST_BUSY = 0;
    localparam int ST_LATCH = 1;
    localparam int ST_LEVEL_LO = 2;
    localparam int ST_LOCK = 7;
    // identification byte, value is arbitrary
    localparam logic [7:0] ID_BYTE = 8'h5c;
    // address map: 4KB sectors, 32KB half blocks, 64KB blocks
    localparam logic [19:0] SECT_MASK = 20'hff000;
    localparam logic [19:0] HALF_MASK = 20'hf8000;
    localparam logic [19:0] BLK_MASK = 20'hf0000;
    localparam int BLK_LO = 16;
    localparam logic [4:0] BLK_TOTAL = 5'h10;
    localparam logic [8:0] PAGE_BYTES = 9'h100;
    // frame lengths in bytes
    localparam logic [9:0] LEN_CMD = 10'h001;
    localparam logic [9:0] LEN_STAT_WR = 10'h002;
    localparam logic [9:0] LEN_ADDR = 10'h004;
    localparam logic [9:0] LEN_MAX = 10'h3ff;

    typedef enum logic [2:0] {
        OPK_PROGRAM, OPK_SECTOR, OPK_HALF, OPK_BLOCK, OPK_CHIP
    } sfcfp_op_kind_t;

    typedef enum {LM_IDLE, LM_ACTIVE, LM_STANDBY} sfcfp_link_mode_t;

    function automatic logic sfcfp_known(input logic [7:0] op);
        case (op)
            OP_SET_LATCH, OP_CLR_LATCH, OP_STAT_RD, OP_STAT_WR, OP_PAGE_WR,
            OP_SECT_ER, OP_HALF_ER, OP_BLK_ER, OP_CHIP_ER_A, OP_CHIP_ER_B,
            OP_SLEEP, OP_READ, OP_FAST_RD, OP_TWO_RD, OP_PARAM_RD,
            OP_IDENT_RD, OP_SIG_RD, OP_MAKER_RD: sfcfp_known = 1'b1;
            default: sfcfp_known = 1'b0;
        endcase
    endfunction : sfcfp_known

    // bytes shifted in before data goes out; zero for no data phase
    function automatic logic [2:0] sfcfp_data_start(input logic [7:0] op);
        case (op)
            OP_STAT_RD, OP_IDENT_RD: sfcfp_data_start = 3'h1;
            OP_READ, OP_SIG_RD, OP_MAKER_RD: sfcfp_data_start = 3'h4;
            OP_FAST_RD, OP_TWO_RD, OP_PARAM_RD: sfcfp_data_start = 3'h5;
            default: sfcfp_data_start = 3'h0;
        endcase
    endfunction : sfcfp_data_start

    // number of protected top blocks for a protect level
    function automatic logic [4:0] sfcfp_prot_count(input logic [3:0] lvl);
        case (lvl)
            4'h0: sfcfp_prot_count = 5'h00;
            4'h1: sfcfp_prot_count = 5'h01;
            4'h2: sfcfp_prot_count = 5'h02;
            4'h3: sfcfp_prot_count = 5'h04;
            4'h4: sfcfp_prot_count = 5'h08;
            default: sfcfp_prot_count = BLK_TOTAL;
        endcase
    endfunction : sfcfp_prot_count
endpackage : sfcfp_pkg

// ==== bench/sfcfp_host_model.sv ====
// Purpose: host serial master for the flash front end
// Assumes: 30 ns link period; clock stands still between frames
// Notes: after a frame the data line shows the inverse of its last bit
`timescale 1ns/1ps
module sfcfp_host_model (
    output logic sclk_out,
    output logic cs_n_out,
    output logic mosi_out,
    input wire logic miso_in
);
    logic cpol = 1'b0;
    logic [7:0] rx_q = 8'h00;
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        mosi_out = 1'b0;
    end
    // bits past the queue shift zeros; rx_q keeps the last 8 bits seen
    task automatic xfer(input logic [7:0] b[$], input int nbits);
        logic [7:0] cur;
        sclk_out = cpol;
        #7 cs_n_out = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            cur = (i / 8 < b.size()) ? b[i / 8] : 8'h00;
            #15 sclk_out = 1'b0;
            mosi_out = cur[7 - i % 8];
            #15 sclk_out = 1'b1;
            rx_q = {rx_q[6:0], miso_in};
        end
        #15 sclk_out = cpol;
        #15 cs_n_out = 1'b1;
        mosi_out = ~mosi_out;
        #75;
    endtask : xfer
endmodule : sfcfp_host_model

// ==== bench/sfcfp_properties.sv ====
// Purpose: port checker for the flash command front end
// Assumes: all checks on clk_sys_in
// Notes: bound to every sfcfp_top
`timescale 1ns/1ps
module sfcfp_properties (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic cs_n_in,
    input wire logic data_line0_oe_out,
    input wire logic data_line1_oe_out,
    input wire logic link_active_out,
    input wire logic [7:0] status_out,
    input wire logic deep_sleep_out,
    input wire logic op_start_out,
    input wire logic [2:0] op_kind_out,
    input wire logic [19:0] op_addr_out,
    input wire logic cmd_refused_out
);
    logic [4:0] free_blocks;
    always_comb begin
        case (status_out[5:2])
            4'h0: free_blocks = 5'h10;
            4'h1: free_blocks = 5'h0f;
            4'h2: free_blocks = 5'h0e;
            4'h3: free_blocks = 5'h0c;
            4'h4: free_blocks = 5'h08;
            default: free_blocks = 5'h00;
        endcase
    end
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_start;
        op_start_out;
    endsequence
    sequence s_chip_go;
        op_start_out && op_kind_out == 3'h4;
    endsequence
    a_start_pulse: assert property (s_start |=> !op_start_out)
        else $error("start pulse too long");
    a_start_latch: assert property (s_start |-> status_out[1])
        else $error("start without write latch");
    a_chip_level: assert property (s_chip_go |-> status_out[5:2] == 4'h0)
        else $error("chip erase with protect level set");
    a_block_free: assert property (
        (s_start and op_kind_out != 3'h4) |-> {1'b0, op_addr_out[19:16]} < free_blocks)
        else $error("operation in protected block");
    a_sector_align: assert property (
        (s_start and op_kind_out == 3'h1) |-> op_addr_out[11:0] == 12'h000)
        else $error("sector address not aligned");
    a_released_idle: assert property (
        cs_n_in |-> !data_line0_oe_out && !data_line1_oe_out && !link_active_out)
        else $error("output or active while deselected");
    a_sleep_quiet: assert property (
        deep_sleep_out |-> !link_active_out && !data_line1_oe_out)
        else $error("activity in deep sleep");
    a_two_line_oe: assert property (data_line0_oe_out |-> data_line1_oe_out)
        else $error("line0 driven outside read phase");
    a_refuse_excl: assert property (
        cmd_refused_out |-> !op_start_out ##1 !op_start_out)
        else $error("refused frame started an operation");
endmodule : sfcfp_properties
bind sfcfp_top sfcfp_properties u_props (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .cs_n_in(cs_n_in), .data_line0_oe_out(data_line0_oe_out),
    .data_line1_oe_out(data_line1_oe_out), .link_active_out(link_active_out),
    .status_out(status_out), .deep_sleep_out(deep_sleep_out), .op_start_out(op_start_out),
    .op_kind_out(op_kind_out), .op_addr_out(op_addr_out), .cmd_refused_out(cmd_refused_out));

// ==== bench/testbench.sv ====
// Purpose: self-checking bench for the flash command front end
// Assumes: backend finishes one cycle after each start
// Notes: frame effects checked once the host gap has passed
`timescale 1ns/1ps
module testbench;
    import sfcfp_pkg::*;
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic wp_n = 1'b1, quad = 1'b0, busy = 1'b0, done = 1'b0;
    logic sclk, cs_n, mosi, d0, d0_oe, d1, d1_oe, active, sleep, start, refused;
    logic [7:0] status, pb_rd, pb_ra = 8'h01;
    logic [23:0] raddr;
    logic [2:0] kind;
    logic [19:0] oaddr;
    logic [8:0] olen;
    int n_errors = 0, n_compared = 0, cyc = 0, n_st = 0, n_rf = 0, n_o0 = 0, n_o1 = 0, n_ac = 0;
    int s0, s1, s2;
    wire line0 = d0_oe ? d0 : mosi;
    wire line1 = d1_oe ? d1 : ~d1;
    sfcfp_top u_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .sclk_in(sclk),
        .cs_n_in(cs_n), .data_line0_in(line0), .data_line0_out(d0), .data_line0_oe_out(d0_oe),
        .data_line1_in(line1), .data_line1_out(d1), .data_line1_oe_out(d1_oe),
        .write_protect_n_in(wp_n), .quad_mode_in(quad), .array_byte_in(8'ha5),
        .read_addr_out(raddr), .link_active_out(active), .status_out(status),
        .deep_sleep_out(sleep), .op_start_out(start), .op_kind_out(kind),
        .op_addr_out(oaddr), .op_len_out(olen), .op_busy_in(busy), .op_done_in(done),
        .pbuf_raddr_in(pb_ra), .pbuf_rdata_out(pb_rd), .cmd_refused_out(refused));
    sfcfp_host_model u_host (.sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi), .miso_in(line1));
    always #2.5 clk_sys_in = ~clk_sys_in;
    always @(negedge clk_sys_in) begin
        done <= busy;
        busy <= start;
    end
    always @(posedge clk_sys_in) begin
        n_st += int'(start === 1'b1);
        n_rf += int'(refused === 1'b1);
        n_o0 += int'(d0_oe === 1'b1);
        n_o1 += int'(d1_oe === 1'b1);
        n_ac += int'(active === 1'b1);
        cyc++;
        if (cyc == 60000) begin
            n_errors++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        if (n_errors == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : wrap_up
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic x(input logic [7:0] b[$], input int n);
        s0 = n_st;
        s1 = n_rf;
        u_host.xfer(b, n);
    endtask : x
    task automatic t_latch();
        check(status, 8'h00);
        x('{OP_SET_LATCH}, 8);
        check(status[1], 1'b1);
        x('{OP_CLR_LATCH}, 8);
        check(status[1], 1'b0);
        x('{OP_SET_LATCH}, 12);
        check(status[1], 1'b0);
        check(n_rf - s1, 1);
    endtask : t_latch
    task automatic t_frames();
        s2 = n_o1;
        x('{8'hff}, 24);
        check(n_o1 - s2 + n_ac, n_ac);
        s2 = n_ac;
        x('{OP_STAT_RD}, 13);
        check(n_ac > s2, 1);
        check(n_rf - s1, 0);
        s2 = n_o0;
        x('{OP_TWO_RD, 8'h12, 8'h34, 8'h56, 8'h00}, 56);
        check(n_o0 > s2, 1);
        check(raddr, 24'h123456);
        check(u_host.rx_q, 8'hcc);
        x('{OP_SLEEP}, 8);
        check(sleep, 1'b1);
        x('{OP_SET_LATCH}, 8);
        check({sleep, status[1]}, 2'b00);
    endtask : t_frames
    task automatic t_hwprot();
        x('{OP_SET_LATCH}, 8);
        x('{OP_STAT_WR, 8'h80}, 16);
        @(negedge clk_sys_in) wp_n = 1'b0;
        x('{OP_SET_LATCH}, 8);
        x('{OP_STAT_WR, 8'h04}, 16);
        check(status, 8'h82);
        @(negedge clk_sys_in) quad = 1'b1;
        x('{OP_STAT_WR, 8'h04}, 16);
        check(status, 8'h04);
        @(negedge clk_sys_in) wp_n = 1'b1;
        quad = 1'b0;
        x('{OP_SET_LATCH}, 8);
        x('{OP_STAT_WR, 8'h00}, 16);
    endtask : t_hwprot
    task automatic t_prog();
        x('{OP_SET_LATCH}, 8);
        x('{OP_PAGE_WR, 8'h00, 8'h01, 8'h23, 8'h3c, 8'hc3}, 48);
        check({kind, oaddr, olen}, {3'h0, 20'h00123, 9'h002});
        check(pb_rd, 8'hc3);
        x('{OP_SET_LATCH}, 8);
        x('{OP_SECT_ER, 8'h0a, 8'hbc, 8'hde}, 32);
        check({kind, oaddr}, {3'h1, 20'hab000});
        x('{OP_SET_LATCH}, 8);
        x('{OP_HALF_ER, 8'h0f, 8'hff, 8'hff}, 32);
        check({kind, oaddr}, {3'h2, 20'hf8000});
    endtask : t_prog
    task automatic t_level(input logic [3:0] lvl);
        int prot;
        logic [3:0] blk[5] = '{4'hf, 4'he, 4'hc, 4'h8, 4'h7};
        prot = lvl == 0 ? 0 : lvl < 5 ? 1 << (lvl - 1) : 16;
        u_host.cpol = lvl[0];
        x('{OP_SET_LATCH}, 8);
        x('{OP_STAT_WR, {2'b00, lvl, 2'b00}}, 16);
        x('{OP_STAT_RD}, 16);
        check(u_host.rx_q, {2'b00, lvl, 2'b00});
        foreach (blk[i]) begin
            x('{OP_SET_LATCH}, 8);
            x('{OP_BLK_ER, {4'h0, blk[i]}, 8'h00, 8'h00}, 32);
            check(n_st - s0, int'(blk[i]) < 16 - prot);
            check(status[1], int'(blk[i]) >= 16 - prot);
        end
        x('{OP_SET_LATCH}, 8);
        x('{lvl[1] ? OP_CHIP_ER_B : OP_CHIP_ER_A}, 8);
        check(n_st - s0, lvl == 0);
    endtask : t_level
    initial begin
        repeat (12) @(negedge clk_sys_in);
        rst_n_in = 1'b1;
        repeat (6) @(negedge clk_sys_in);
        t_latch();
        t_frames();
        t_hwprot();
        t_prog();
        for (int l = 0; l < 16; l++) t_level(l[3:0]);
        wrap_up();
    end
endmodule : testbench
